// ### post_pkg.sv
package post_pkg;
	localparam int ERR_W = 8;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam int BIT_SRAM = 0;
	localparam int BIT_CODE = 1;
	localparam int BIT_DATA = 2;
	localparam int BIT_COMM = 3;
	localparam int BIT_OUT = 4;
	localparam int N_ITEMS = 3;
	localparam int ITEM_DISPLAY = 0;
	localparam int ITEM_WAVEFORM = 1;
	localparam int ITEM_REMOTE = 2;
	localparam int PROT_W = 8;
	localparam int MEAS_W = 16;
	// test voltage and window, in volts
	localparam logic [15:0] TEST_VOLT = 16'h012c;
	localparam logic [15:0] TOL_VOLT = 16'h0005;
	localparam logic [15:0] WIN_LO = TEST_VOLT - TOL_VOLT;
	localparam logic [15:0] WIN_HI = TEST_VOLT + TOL_VOLT;
	typedef enum logic [2:0] {
		POST_CLEAR, POST_MEM, POST_MEM_WAIT, POST_PROT,
		POST_PROG, POST_MEAS_WAIT, POST_DONE
	} post_state_e;
endpackage

// ### post_seq.sv
// Contract
// - after power-on reset run memory, data and link checks before output
// - report error code for display, waveform and remote items
// - bit 0 set on SRAM fail, bit 2 on stored-data fail
// - bit 1 set on program code integrity fail
// - bit 3 on link fail, bit 4 on output fail, 5-7 reserved zero
// - output self-test starts only after memory, data, link checks done
// - output relays stay open for the whole output self-test
// - protection asserted fails output test and keeps its type
// - else program 300V, measure, fail outside 295 to 305 volts
module post_seq #(
	parameter int MEAS_W = post_pkg::MEAS_W,
	parameter int PROT_W = post_pkg::PROT_W
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	// per item: sram, code, data, link check results
	output logic mem_start_o,
	input wire logic [post_pkg::N_ITEMS-1:0] mem_done_i,
	input wire logic [post_pkg::N_ITEMS-1:0] sram_fail_i,
	input wire logic [post_pkg::N_ITEMS-1:0] code_fail_i,
	input wire logic [post_pkg::N_ITEMS-1:0] data_fail_i,
	input wire logic [post_pkg::N_ITEMS-1:0] comm_fail_i,
	input wire logic [PROT_W-1:0] prot_i,
	output logic relay_close_o,
	output logic prog_en_o,
	output logic [MEAS_W-1:0] prog_volt_o,
	input wire logic meas_valid_i,
	input wire logic [MEAS_W-1:0] meas_volt_i,
	output logic [7:0] err_display_o,
	output logic [7:0] err_waveform_o,
	output logic [7:0] err_remote_o,
	output logic [post_pkg::N_ITEMS-1:0] item_fail_o,
	output logic test_failed_indication_o,
	output logic [PROT_W-1:0] prot_type_o,
	output logic busy_o,
	output logic done_o
);
	// 9 bits is the least that holds the test voltage and its window
	if (MEAS_W < 9 || PROT_W < 1)
	begin : g_bad_param
		$error("post_seq: parameter out of range");
	end

	post_pkg::post_state_e state_q, state_d;
	logic [7:0] err_q [post_pkg::N_ITEMS];
	logic [post_pkg::N_ITEMS-1:0] fail_q;
	logic [PROT_W-1:0] prot_q;
	logic ng_q, start_q, prog_q, busy_q, done_q, relay_q;
	logic [MEAS_W-1:0] volt_q;

	wire all_mem_done = &mem_done_i;
	wire prot_hit = |prot_i;
	wire [MEAS_W-1:0] win_lo = MEAS_W'(post_pkg::WIN_LO);
	wire [MEAS_W-1:0] win_hi = MEAS_W'(post_pkg::WIN_HI);
	wire meas_bad = (meas_volt_i < win_lo) || (meas_volt_i > win_hi);
	wire out_fail_now = (state_q == post_pkg::POST_PROT && prot_hit)
		|| (state_q == post_pkg::POST_MEAS_WAIT && meas_valid_i && meas_bad);

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			post_pkg::POST_CLEAR: state_d = post_pkg::POST_MEM;
			post_pkg::POST_MEM: state_d = post_pkg::POST_MEM_WAIT;
			post_pkg::POST_MEM_WAIT:
				if (all_mem_done)
					state_d = post_pkg::POST_PROT;
			post_pkg::POST_PROT:
				state_d = prot_hit ? post_pkg::POST_DONE : post_pkg::POST_PROG;
			post_pkg::POST_PROG: state_d = post_pkg::POST_MEAS_WAIT;
			post_pkg::POST_MEAS_WAIT:
				if (meas_valid_i)
					state_d = post_pkg::POST_DONE;
			post_pkg::POST_DONE: state_d = post_pkg::POST_DONE;
			default: state_d = post_pkg::POST_CLEAR;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_q <= post_pkg::POST_CLEAR;
		else
			state_q <= state_d;
	end

	// memory, data and link results latch per item; bits 5-7 stay zero
	genvar gi;
	for (gi = 0; gi < post_pkg::N_ITEMS; gi++)
	begin : g_item
		wire [7:0] mem_bits = {3'h0, 1'b0, comm_fail_i[gi], data_fail_i[gi],
			code_fail_i[gi], sram_fail_i[gi]};
		always_ff @(posedge clk_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
				err_q[gi] <= post_pkg::ERR_RESET;
			else if (state_q == post_pkg::POST_CLEAR)
				err_q[gi] <= post_pkg::ERR_RESET;
			else if (state_q == post_pkg::POST_MEM_WAIT && all_mem_done)
				err_q[gi] <= mem_bits;
			else if (out_fail_now)
				err_q[gi][post_pkg::BIT_OUT] <= 1'b1;
		end
		always_ff @(posedge clk_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
				fail_q[gi] <= 1'b0;
			else
				fail_q[gi] <= |err_q[gi];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			prot_q <= '0;
			ng_q <= 1'b0;
			start_q <= 1'b0;
			prog_q <= 1'b0;
			volt_q <= '0;
			busy_q <= 1'b1;
			done_q <= 1'b0;
			relay_q <= 1'b0;
		end
		else
		begin
			if (state_q == post_pkg::POST_CLEAR)
				ng_q <= 1'b0;
			else if (out_fail_now)
				ng_q <= 1'b1;
			// kept until reset so the operator can ask for the type later
			if (state_q == post_pkg::POST_PROT && prot_hit)
				prot_q <= prot_i;
			start_q <= (state_d == post_pkg::POST_MEM);
			prog_q <= (state_d == post_pkg::POST_MEAS_WAIT);
			volt_q <= (state_d == post_pkg::POST_MEAS_WAIT)
				? MEAS_W'(post_pkg::TEST_VOLT) : '0;
			busy_q <= (state_d != post_pkg::POST_DONE);
			done_q <= (state_d == post_pkg::POST_DONE);
			relay_q <= 1'b0;
		end
	end

	assign mem_start_o = start_q;
	// relays are never closed by this block; the run stage owns them later
	assign relay_close_o = relay_q;
	assign prog_en_o = prog_q;
	assign prog_volt_o = volt_q;
	assign err_display_o = err_q[post_pkg::ITEM_DISPLAY];
	assign err_waveform_o = err_q[post_pkg::ITEM_WAVEFORM];
	assign err_remote_o = err_q[post_pkg::ITEM_REMOTE];
	assign item_fail_o = fail_q;
	assign test_failed_indication_o = ng_q;
	assign prot_type_o = prot_q;
	assign busy_o = busy_q;
	assign done_o = done_q;

	chk_prot_fails: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_PROT && prot_hit |=> ng_q && prot_q != '0)
		else $error("protection did not fail output test");
	chk_window_fail: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEAS_WAIT && meas_valid_i && meas_bad
		|=> err_q[0][post_pkg::BIT_OUT] && ng_q)
		else $error("out of window reading not flagged");
	chk_window_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEAS_WAIT && meas_valid_i && !meas_bad
		|=> !ng_q)
		else $error("in window reading flagged");
	chk_prog_volt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		prog_q |-> prog_volt_o == MEAS_W'(post_pkg::TEST_VOLT))
		else $error("wrong test voltage");
	chk_order_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEM_WAIT && !all_mem_done
		|=> state_q != post_pkg::POST_PROT && !prog_q)
		else $error("output test before checks done");
	chk_relay_open: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		prog_q |-> !relay_close_o)
		else $error("relay closed during output test");
	chk_clear_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_CLEAR |=> err_q[1] == 8'h00 && !ng_q)
		else $error("error code not cleared");
	chk_sram_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEM_WAIT && all_mem_done
		|=> err_q[0][post_pkg::BIT_SRAM] == $past(sram_fail_i[0])
		&& err_q[0][post_pkg::BIT_DATA] == $past(data_fail_i[0])
		&& err_q[0][7:5] == 3'h0)
		else $error("memory bits wrong");
	chk_code_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEM_WAIT && all_mem_done
		|=> err_q[2][post_pkg::BIT_CODE] == $past(code_fail_i[2]))
		else $error("code bit wrong");
	chk_item_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		err_q[1] != 8'h00 |=> item_fail_o[1])
		else $error("item fail not shown");
	chk_start_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_CLEAR |=> mem_start_o)
		else $error("checks not started");
	chk_mem_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		mem_start_o |=> !mem_start_o)
		else $error("check start longer than one cycle");
	chk_done_busy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		done_o |-> !busy_o)
		else $error("busy while done");
	chk_comm_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEM_WAIT && all_mem_done
		|=> err_q[1][post_pkg::BIT_COMM] == $past(comm_fail_i[1]))
		else $error("link bit wrong");
	chk_out_items: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		out_fail_now |=> err_q[0][post_pkg::BIT_OUT]
		&& err_q[1][post_pkg::BIT_OUT] && err_q[2][post_pkg::BIT_OUT])
		else $error("output fail bit missing");
	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		err_q[2][7:5] == 3'h0)
		else $error("reserved bits set");
	chk_prot_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_DONE |=> $stable(prot_q))
		else $error("protection type lost");
	chk_meas_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_q == post_pkg::POST_MEAS_WAIT && meas_valid_i
		|=> !prog_q && done_q)
		else $error("output test did not end");
endmodule

// ### post_far_model.sv
module post_far_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic mem_start_i,
	input wire logic prog_en_i,
	input wire logic [15:0] volt_i,
	output logic [2:0] mem_done_o,
	output logic meas_valid_o,
	output logic [15:0] meas_volt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_q;
	logic [2:0] m_q;
	// items finish at skewed times
	assign mem_done_o = {cnt_q > 5'h09, cnt_q > 5'h05, cnt_q > 5'h02};
	assign meas_valid_o = prog_en_i && (m_q == 3'h4);
	// inverted off the strobe so a stale sample cannot pass
	assign meas_volt_o = meas_valid_o ? volt_i : ~volt_i;
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_q <= 5'h00;
			m_q <= 3'h0;
		end
		else
		begin
			if ((mem_start_i || cnt_q != 5'h00) && cnt_q != 5'h1f)
				cnt_q <= cnt_q + 5'h01;
			if (prog_en_i)
				m_q <= m_q + 3'h1;
		end
	end
endmodule

// ### tb_power_on_self_test_sequencer.sv
module tb_power_on_self_test_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b1;
	logic [2:0] sram_fail_i = '0, code_fail_i = '0, data_fail_i = '0;
	logic [2:0] comm_fail_i = '0, mem_done_i, item_fail_o;
	logic [7:0] prot_i = '0, prot_type_o, err_display_o, err_waveform_o;
	logic [7:0] err_remote_o;
	logic [15:0] volt = '0, meas_volt_i, prog_volt_o;
	logic mem_start_o, relay_close_o, prog_en_o, meas_valid_i, busy_o, done_o;
	logic test_failed_indication_o, done_d;
	logic [2:0] item_exp;
	logic item_pend = 1'b0;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	int miscompares = 0, check_count = 0, cycles = 0;
	post_seq DUT (.clk_i, .arst_n_i, .mem_start_o, .mem_done_i, .sram_fail_i,
		.code_fail_i, .data_fail_i, .comm_fail_i, .prot_i, .relay_close_o,
		.prog_en_o, .prog_volt_o, .meas_valid_i, .meas_volt_i, .err_display_o,
		.err_waveform_o, .err_remote_o, .item_fail_o, .test_failed_indication_o,
		.prot_type_o, .busy_o, .done_o);
	post_far_model far (.clk_i, .arst_n_i, .mem_start_i(mem_start_o),
		.prog_en_i(prog_en_o), .volt_i(volt), .mem_done_o(mem_done_i),
		.meas_valid_o(meas_valid_i), .meas_volt_o(meas_volt_i));
	initial
		forever #4 clk_i = ~clk_i;
	task automatic cmp_code(input logic [7:0] got, input logic [7:0] ex);
		check_count++;
		if (got !== ex)
		begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, ex);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic ex);
		cmp_code({7'h00, got}, {7'h00, ex});
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic run(input logic [11:0] f, input logic [7:0] p,
		input logic [15:0] v);
		logic o;
		o = |p || v < post_pkg::WIN_LO || v > post_pkg::WIN_HI;
		arst_n_i <= 1'b0;
		{comm_fail_i, data_fail_i, code_fail_i, sram_fail_i} <= f;
		prot_i <= p;
		volt <= v;
		exp_q.push_back({3'h0, o, f[9], f[6], f[3], f[0], 3'h0, o, f[10],
			f[7], f[4], f[1], 3'h0, o, f[11], f[8], f[5], f[2], o, p});
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (60) @(posedge clk_i)
			if (done_o === 1'b1)
				break;
		// item flags follow the codes by a cycle; look before the next reset
		@(posedge clk_i);
		$display("test end f=%h p=%h v=%0d", f, p, v);
	endtask
	always @(posedge clk_i)
	begin
		done_d <= done_o;
		cycles++;
		if (arst_n_i && !(&mem_done_i))
			cmp_bit(prog_en_o, 1'b0);
		if (prog_en_o === 1'b1)
			cmp_bit(prog_volt_o === post_pkg::TEST_VOLT, 1'b1);
		cmp_bit(relay_close_o, 1'b0);
		cmp_bit(busy_o === !done_o, 1'b1);
		if (item_pend)
		begin
			cmp_bit(item_fail_o === item_exp, 1'b1);
			item_pend = 1'b0;
		end
		if (mem_start_o === 1'b1)
			cmp_code(err_display_o | err_waveform_o | err_remote_o, 8'h00);
		if (done_o === 1'b1 && done_d !== 1'b1)
		begin
			e = exp_q.pop_front();
			cmp_code(err_display_o, e[32:25]);
			cmp_code(err_waveform_o, e[24:17]);
			cmp_code(err_remote_o, e[16:9]);
			item_exp = {|e[16:9], |e[24:17], |e[32:25]};
			item_pend = 1'b1;
			cmp_bit(test_failed_indication_o, e[8]);
			cmp_code(prot_type_o, e[7:0]);
		end
		if (cycles == 20000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	initial
	begin
		void'($urandom(32'h7b3757ae));
		run(12'h000, 8'h00, 16'h012c);
		run(12'h855, 8'h00, 16'h0127);
		run(12'h000, 8'h10, 16'h012c);
		run(12'h000, 8'h00, 16'h0132);
		run(12'h000, 8'h00, 16'h0126);
		run(12'h000, 8'h00, 16'h0131);
		run(12'hfff, 8'h80, 16'h0000);
		repeat (6)
			run(12'($urandom), ($urandom_range(1) == 0) ? 8'h00 : 8'($urandom),
				16'h0122 + 16'($urandom_range(20)));
		@(posedge clk_i);
		cmp_bit(exp_q.size() == 0, 1'b1);
		print_verdict();
	end
endmodule
